// *** sipt_input_port.sv ***
// Purpose: eight-lane serial audio input port with shared buffer
// Assumes: dma engine outside answers dma_req with dma_ack
// Notes: lane 0 may instead carry the 20-bit parallel input
`include "sipt_map.svh"
module sipt_input_port
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [`SIPT_CHANS-1:0] chan_en,
  input wire sipt_pkg::sipt_fmt_type fmt,
  input wire sipt_pkg::sipt_width_type wid,
  input wire logic par_mode,
  input wire logic [`SIPT_CHANS-1:0] sclk,
  input wire logic [`SIPT_CHANS-1:0] fsync,
  input wire logic [`SIPT_CHANS-1:0] sdata,
  input wire logic par_clk,
  input wire logic par_frame,
  input wire logic [`SIPT_PAR_W-1:0] par_data,
  input wire logic [`SIPT_CHANS-1:0] dma_ack,
  input wire logic ovf_clr,
  output logic [`SIPT_CHANS-1:0] dma_req,
  output logic [`SIPT_WORD_W-1:0] dma_data,
  output logic [`SIPT_CHAN_W-1:0] dma_chan,
  output logic overflow,
  output logic [`SIPT_CNT_W-1:0] level
);
  import sipt_pkg::*;

  logic [`SIPT_CHANS-1:0] pend; // lane has a word waiting
  logic [`SIPT_WORD_W-1:0] lane_word [`SIPT_CHANS];
  logic [`SIPT_CHANS-1:0] grant; // lane taken this cycle
  logic [`SIPT_CHANS-1:0] take; // clears lane holding stage
  logic [`SIPT_CHANS-1:0] ser_en; // serial lanes allowed to run
  logic [`SIPT_WORD_W-1:0] sel_word;
  logic [`SIPT_CHAN_W-1:0] sel_chan;
  logic push_req; // some word offered this cycle
  logic push; // word actually stored
  logic pop; // dma took the head word
  logic full;
  logic empty;
  logic [`SIPT_WORD_W-1:0] mem [`SIPT_FIFO_DEPTH]; // shared buffer
  logic [`SIPT_CHAN_W-1:0] tag [`SIPT_FIFO_DEPTH]; // owning lane
  logic [`SIPT_PTR_W-1:0] wr_r;
  logic [`SIPT_PTR_W-1:0] rd_r;
  logic [`SIPT_CNT_W-1:0] cnt_r;
  logic ovf_r;
  logic [2:0] psync1_r; // first stage, read only by second
  logic [2:0] psync2_r; // {par_clk, par_frame, spare}
  logic [`SIPT_PAR_W-1:0] pdat1_r;
  logic [`SIPT_PAR_W-1:0] pdat2_r;
  logic pclk_d_r;
  logic par_pend_r; // parallel sample waiting
  logic [`SIPT_WORD_W-1:0] par_word_r;

  // lane 0 is muted when the parallel input owns it
  always_comb
  begin
    ser_en = chan_en;
    if (par_mode)
      ser_en[`SIPT_PAR_LANE] = 1'b0;
  end

  // one receiver per lane, each on its own pins
  genvar gi;
  generate
    for (gi = 0; gi < `SIPT_CHANS; gi++)
    begin : g_lane
      sipt_rx_chan u_rx
      (
        .clock(clock),
        .rstn(rstn),
        .enable(ser_en[gi]),
        .fmt(fmt),
        .wid(wid),
        .sclk(sclk[gi]),
        .fsync(fsync[gi]),
        .sdata(sdata[gi]),
        .take(take[gi]),
        .pend(pend[gi]),
        .word(lane_word[gi])
      );
    end
  endgenerate

  // parallel input pins pass two flops before use
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      psync1_r <= 3'h0;
      psync2_r <= 3'h0;
      pdat1_r <= 20'h0;
      pdat2_r <= 20'h0;
      pclk_d_r <= 1'b0;
    end
    else
    begin
      psync1_r <= {par_clk, par_frame, 1'b0};
      psync2_r <= psync1_r;
      pdat1_r <= par_data;
      pdat2_r <= pdat1_r;
      pclk_d_r <= psync2_r[2];
    end
  end

  // parallel sample on rising strobe while frame is high
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      par_pend_r <= 1'b0;
      par_word_r <= 32'h0;
    end
    else if (par_mode && psync2_r[1] && psync2_r[2] && !pclk_d_r)
    begin
      par_pend_r <= 1'b1;
      par_word_r <= {pdat2_r, 12'h000};
    end
    else if (grant[`SIPT_PAR_LANE] && par_mode)
      par_pend_r <= 1'b0;
  end

  // fixed priority merge; lanes are slow so none waits long
  always_comb
  begin
    logic [`SIPT_CHANS-1:0] req;
    req = pend;
    req[`SIPT_PAR_LANE] = par_mode ? par_pend_r : pend[`SIPT_PAR_LANE];
    grant = 8'h00;
    sel_word = 32'h0;
    sel_chan = 3'h0;
    for (int i = `SIPT_CHANS - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        grant = 8'h00;
        grant[i] = 1'b1;
        sel_chan = 3'(i);
        sel_word = lane_word[i];
      end
    end
    if (par_mode && grant[`SIPT_PAR_LANE])
      sel_word = par_word_r;
    take = grant;
    if (par_mode)
      take[`SIPT_PAR_LANE] = 1'b0;
  end

  assign full = (cnt_r == 4'(`SIPT_FIFO_DEPTH));
  assign empty = (cnt_r == 4'h0);
  assign push_req = |grant;
  assign push = push_req && !full;
  assign pop = |(dma_ack & dma_req);

  // head word is requested on its own lane's dma channel
  always_comb
  begin
    dma_req = 8'h00;
    if (!empty)
      dma_req[tag[rd_r]] = 1'b1;
  end

  // buffer storage, written only when not full
  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem[wr_r] <= sel_word;
      tag[wr_r] <= sel_chan;
    end
  end

  // pointers and fill count
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_r <= 3'h0;
      rd_r <= 3'h0;
      cnt_r <= 4'h0;
    end
    else
    begin
      if (push)
        wr_r <= wr_r + 3'h1;
      if (pop)
        rd_r <= rd_r + 3'h1;
      if (push && !pop)
        cnt_r <= cnt_r + 4'h1;
      else if (pop && !push)
        cnt_r <= cnt_r - 4'h1;
    end
  end

  // sticky overflow; a new loss wins over the clear
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      ovf_r <= 1'b0;
    else if (push_req && full)
      ovf_r <= 1'b1;
    else if (ovf_clr)
      ovf_r <= 1'b0;
  end

  assign dma_data = mem[rd_r];
  assign dma_chan = tag[rd_r];
  assign overflow = ovf_r;
  assign level = cnt_r;

  a_fifo_depth: assert property (@(posedge clock) disable iff (!rstn)
    cnt_r <= 4'h8)
    else $error("buffer count above eight");
  a_full_discard: assert property (@(posedge clock) disable iff (!rstn)
    push_req && full && !pop |=> cnt_r == 4'h8 && ovf_r)
    else $error("word into full buffer not dropped");
  a_ovf_sticky: assert property (@(posedge clock) disable iff (!rstn)
    ovf_r && !ovf_clr |=> ovf_r)
    else $error("overflow flag fell without clear");
  a_ovf_cause: assert property (@(posedge clock) disable iff (!rstn)
    $rose(ovf_r) |-> $past(push_req) && $past(full))
    else $error("overflow set without a lost word");
  a_grant_single: assert property (@(posedge clock) disable iff (!rstn)
    $onehot0(grant) && (push_req == |pend || par_mode))
    else $error("merge granted other than one lane");
  a_dma_onehot: assert property (@(posedge clock) disable iff (!rstn)
    $onehot0(dma_req) && (empty == (dma_req == 8'h00)))
    else $error("dma request not one lane or idle wrong");
  a_pop_level: assert property (@(posedge clock) disable iff (!rstn)
    pop && !push |=> cnt_r == $past(cnt_r) - 4'h1)
    else $error("dma pop did not lower level");
  a_par_lane: assert property (@(posedge clock) disable iff (!rstn)
    par_mode |-> !pend[`SIPT_PAR_LANE] ##1 !take[`SIPT_PAR_LANE])
    else $error("serial lane 0 active in parallel mode");
endmodule : sipt_input_port

// *** sipt_input_port_tb.sv ***
// Purpose: self-checking bench of the multichannel serial input port
// Assumes: source model on the far side, bench acts as dma engine
// Notes: expected words queued by the driver, popped by the monitor
module sipt_input_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sipt_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] chan_en = 8'h00;
  sipt_fmt_type fmt = SIPT_FMT_I2S;
  sipt_width_type wid = SIPT_W32;
  logic par_mode = 1'b0;
  logic ovf_clr = 1'b0;
  logic [7:0] dma_ack = 8'h00;
  wire logic [7:0] sclk, fsync, sdata;
  wire logic par_clk, par_frame;
  wire logic [19:0] par_data;
  logic [7:0] dma_req;
  logic [31:0] dma_data;
  logic [2:0] dma_chan;
  logic overflow;
  logic [3:0] level;
  int failures = 0;
  int tests_run = 0;
  int seed = 32'h0882; // fixed seed
  int cycles = 0;
  logic ack_on = 1'b1; // low stalls the dma side
  logic [7:0] pop_mask = 8'h00;
  logic [34:0] exp_q[$]; // {lane, word} in push order
  logic [7:0][3:0][31:0] w;
  logic [3:0][19:0] pw;
  logic [7:0] mask;
  sipt_fmt_type fl[8] = '{SIPT_FMT_I2S, SIPT_FMT_I2S, SIPT_FMT_LJ,
    SIPT_FMT_LJ, SIPT_FMT_RJ, SIPT_FMT_RJ, SIPT_FMT_RJ, SIPT_FMT_RJ};
  sipt_width_type wl[8] = '{SIPT_W32, SIPT_W24, SIPT_W32, SIPT_W24,
    SIPT_W24, SIPT_W20, SIPT_W18, SIPT_W16};
  // device under test
  sipt_input_port uut
  (
    .clock(clock), .rstn(rstn), .chan_en(chan_en), .fmt(fmt), .wid(wid),
    .par_mode(par_mode), .sclk(sclk), .fsync(fsync), .sdata(sdata),
    .par_clk(par_clk), .par_frame(par_frame), .par_data(par_data),
    .dma_ack(dma_ack), .ovf_clr(ovf_clr), .dma_req(dma_req),
    .dma_data(dma_data), .dma_chan(dma_chan), .overflow(overflow),
    .level(level)
  );
  // far-side sources
  sipt_src_model src
  (
    .clock(clock), .sclk(sclk), .fsync(fsync), .sdata(sdata),
    .par_clk(par_clk), .par_frame(par_frame), .par_data(par_data)
  );
  // 50 MHz clock
  always #10 clock = ~clock;
  // verdict and end of run
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  // hang guard, well above the expected run length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      complete_run();
    end
  end
  // one comparison
  task automatic check(input logic [34:0] got, input logic [34:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // word the port should deliver for one 32-bit half
  function automatic logic [31:0] exp_word(input sipt_fmt_type f,
    input sipt_width_type d, input logic [31:0] h);
    int n;
    n = (d == SIPT_W20) ? 20 : (d == SIPT_W18) ? 18 :
      (d == SIPT_W16) ? 16 : 24;
    if (f != SIPT_FMT_RJ)
      n = (d == SIPT_W32) ? 32 : 24;
    if (f == SIPT_FMT_RJ)
      return h << (32 - n);
    return (h >> (32 - n)) << (32 - n);
  endfunction : exp_word
  // monitor: looks at settled outputs mid-cycle, random dma stalls
  always @(negedge clock)
  begin
    logic [34:0] head; // oldest expected {lane, word}
    head = 35'h0;
    pop_mask = 8'h00;
    if (dma_req !== 8'h00 && dma_ack === 8'h00 && ack_on
      && ($random(seed) & 3) != 0)
    begin
      head = exp_q.size() ? exp_q.pop_front() : 'x;
      check({dma_chan, dma_data}, head);
      check({27'h0, dma_req}, {27'h0, 8'h01 << head[34:32]});
      pop_mask = dma_req;
    end
  end
  // one-cycle ack on the rising edge
  always @(posedge clock)
    dma_ack <= pop_mask;
  // reset held two cycles
  task automatic do_reset();
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
  endtask : do_reset
  // wait for every queued word to drain, bounded
  task automatic wait_done(input string name);
    int i;
    for (i = 0; i < 2000 && (exp_q.size() != 0 || level !== 4'h0); i++)
      @(posedge clock);
    check({34'h0, exp_q.size() == 0}, 35'h1);
    $display("test %s done", name);
  endtask : wait_done
  // main sequence
  initial
  begin
    // every format and width, random lane sets, one pair per lane
    for (int k = 0; k < 8; k++)
    begin
      // lanes off while the parked sync level is clocked in
      chan_en <= 8'h00;
      do_reset();
      src.park(fl[k]);
      mask = 8'($random(seed));
      mask[k] = 1'b1;
      fmt <= fl[k];
      wid <= wl[k];
      chan_en <= mask;
      for (int h = 0; h < 2; h++)
        for (int l = 0; l < 8; l++)
        begin
          w[l][h] = $random(seed);
          if (mask[l])
            exp_q.push_back({l[2:0], exp_word(fl[k], wl[k], w[l][h])});
        end
      src.send(fl[k], 2, w);
      wait_done("format");
    end
    // full buffer: second halves dropped, sticky flag
    chan_en <= 8'h00;
    do_reset();
    src.park(SIPT_FMT_LJ);
    fmt <= SIPT_FMT_LJ;
    wid <= SIPT_W32;
    chan_en <= 8'hFF;
    ack_on = 1'b0;
    for (int h = 0; h < 2; h++)
      for (int l = 0; l < 8; l++)
      begin
        w[l][h] = $random(seed);
        if (h == 0)
          exp_q.push_back({l[2:0], w[l][h]});
      end
    src.send(SIPT_FMT_LJ, 2, w);
    repeat (20) @(posedge clock);
    @(negedge clock);
    check({31'h0, level}, 35'h8);
    check({34'h0, overflow}, 35'h1);
    ack_on = 1'b1;
    wait_done("overflow drain");
    check({34'h0, overflow}, 35'h1);
    ovf_clr <= 1'b1;
    @(posedge clock);
    ovf_clr <= 1'b0;
    @(negedge clock);
    check({34'h0, overflow}, 35'h0);
    // lane 0 as the 20-bit parallel input
    do_reset();
    par_mode <= 1'b1;
    chan_en <= 8'h01;
    for (int i = 0; i < 3; i++)
    begin
      pw[i] = 20'($random(seed));
      exp_q.push_back({3'h0, pw[i], 12'h000});
    end
    src.par_send(3, pw);
    wait_done("parallel");
    complete_run();
  end
endmodule : sipt_input_port_tb

// *** sipt_map.svh ***
// Purpose: constants of the multichannel serial input port
// Assumes: 50 MHz system clock, link bit clocks far slower than it
// Notes: widths, depths and codes shared by the port and its receive lanes
// Functional notes
// - eight channels, each own clock, sync, data
// - all channels merge into 32x8 shared buffer
// - frame is 64 bits, split in two words
// - i2s, left-justified or right-justified format per configuration
// - one pair per sync period, pushed per half
// - widths 24/32 justified, 24/20/18/16 right
// - dma drains buffer without core involvement
// - every data channel has its own dma request
// - eight serial, or seven plus 20-bit parallel
`ifndef SIPT_MAP_SVH
`define SIPT_MAP_SVH
`define SIPT_CHANS 8
`define SIPT_CHAN_W 3
`define SIPT_WORD_W 32
`define SIPT_FIFO_DEPTH 8
`define SIPT_PTR_W 3
`define SIPT_CNT_W 4
`define SIPT_PAR_W 20
`define SIPT_BITS_W 6
`define SIPT_HALF_BITS 6'h20
`define SIPT_JUST_BITS 6'h18
`define SIPT_PAR_LANE 0
`endif

// *** sipt_pkg.sv ***
// Purpose: types of the multichannel serial input port
// Assumes: sipt_map.svh constants
// Notes: format and width codes are configuration inputs
package sipt_pkg;
  // serial framing format
  typedef enum logic [1:0] {
    SIPT_FMT_I2S = 2'h0,
    SIPT_FMT_LJ = 2'h1,
    SIPT_FMT_RJ = 2'h2
  } sipt_fmt_type;
  // sample width codes
  typedef enum logic [2:0] {
    SIPT_W32 = 3'h0,
    SIPT_W24 = 3'h1,
    SIPT_W20 = 3'h2,
    SIPT_W18 = 3'h3,
    SIPT_W16 = 3'h4
  } sipt_width_type;
  // receive channel framing states, one-hot
  typedef enum logic [1:0] {
    SIPT_ST_SEEK = 2'b01,
    SIPT_ST_RUN = 2'b10
  } sipt_state_type;
endpackage : sipt_pkg

// *** sipt_rx_chan.sv ***
// Purpose: one serial receive lane, pins to half-frame words
// Assumes: bit clock at most a quarter of clock; pins asynchronous
// Notes: words are left-justified, unused low bits zero
`include "sipt_map.svh"
module sipt_rx_chan
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic enable,
  input wire sipt_pkg::sipt_fmt_type fmt,
  input wire sipt_pkg::sipt_width_type wid,
  input wire logic sclk,
  input wire logic fsync,
  input wire logic sdata,
  input wire logic take,
  output logic pend,
  output logic [`SIPT_WORD_W-1:0] word
);
  import sipt_pkg::*;

  logic [2:0] sync1_r; // first stage, read only by second
  logic [2:0] sync2_r; // {sclk, fsync, sdata} settled
  logic sclk_d_r; // previous settled bit clock
  logic fs_prev_r; // sync level at previous rising edge
  logic rise; // bit clock rising edge
  logic fs_chg; // half-frame boundary
  sipt_state_type st_r;
  logic [`SIPT_WORD_W-1:0] sh_r; // collected bits of this half
  logic [`SIPT_BITS_W-1:0] cnt_r; // bits collected, saturates
  logic [`SIPT_WORD_W-1:0] sh_acc; // shifter with this edge's bit
  logic [`SIPT_BITS_W-1:0] cnt_acc;
  logic [`SIPT_BITS_W-1:0] wbits; // effective sample width
  logic is_rj;
  logic emit; // a half-frame word is complete
  logic [`SIPT_WORD_W-1:0] emit_word;

  // two-stage synchronisers for all three pins
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {sclk, fsync, sdata};
      sync2_r <= sync1_r;
      sclk_d_r <= sync2_r[2];
    end
  end

  assign rise = sync2_r[2] & ~sclk_d_r;
  assign fs_chg = rise & (sync2_r[1] != fs_prev_r);
  assign is_rj = (fmt == SIPT_FMT_RJ);

  // width decode; justified formats only know 24 and 32
  always_comb
  begin
    case (wid)
      SIPT_W32: wbits = is_rj ? 6'h18 : `SIPT_HALF_BITS;
      SIPT_W20: wbits = is_rj ? 6'h14 : `SIPT_JUST_BITS;
      SIPT_W18: wbits = is_rj ? 6'h12 : `SIPT_JUST_BITS;
      SIPT_W16: wbits = is_rj ? 6'h10 : `SIPT_JUST_BITS;
      default: wbits = `SIPT_JUST_BITS;
    endcase
  end

  // justified keeps first 32 bits, right-justified keeps last 32
  assign sh_acc = (is_rj || cnt_r < `SIPT_HALF_BITS) ?
    {sh_r[`SIPT_WORD_W-2:0], sync2_r[0]} : sh_r;
  assign cnt_acc = (cnt_r < `SIPT_HALF_BITS) ? cnt_r + 6'h1 : cnt_r;

  // i2s lsb arrives on the boundary edge, one bit late
  always_comb
  begin
    logic [`SIPT_WORD_W-1:0] src;
    logic [`SIPT_BITS_W-1:0] n;
    logic [`SIPT_WORD_W-1:0] left;
    left = 32'h0;
    src = (fmt == SIPT_FMT_I2S) ? sh_acc : sh_r;
    n = (fmt == SIPT_FMT_I2S) ? cnt_acc : cnt_r;
    if (is_rj)
      left = src << (`SIPT_HALF_BITS - wbits);
    else
      left = src << (`SIPT_HALF_BITS - n);
    emit_word = left & ~({`SIPT_WORD_W{1'b1}} >> wbits);
    emit = fs_chg && enable && (st_r == SIPT_ST_RUN);
  end

  // framing: wait for a boundary so the first word is whole
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= SIPT_ST_SEEK;
      sh_r <= 32'h0;
      cnt_r <= 6'h0;
      fs_prev_r <= 1'b0;
    end
    else if (rise)
    begin
      fs_prev_r <= sync2_r[1];
      case (st_r)
        SIPT_ST_SEEK:
        begin
          if (fs_chg && enable)
            st_r <= SIPT_ST_RUN;
        end
        SIPT_ST_RUN:
        begin
          if (!enable)
            st_r <= SIPT_ST_SEEK;
        end
        default: st_r <= SIPT_ST_SEEK;
      endcase
      if (fs_chg && fmt == SIPT_FMT_I2S)
      begin
        // boundary bit closed the old half
        sh_r <= 32'h0;
        cnt_r <= 6'h0;
      end
      else if (fs_chg)
      begin
        // boundary bit is msb of the new half
        sh_r <= {31'h0, sync2_r[0]};
        cnt_r <= 6'h1;
      end
      else
      begin
        sh_r <= sh_acc;
        cnt_r <= cnt_acc;
      end
    end
  end

  // one-word holding stage; a new word wins over take
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pend <= 1'b0;
      word <= 32'h0;
    end
    else if (emit)
    begin
      pend <= 1'b1;
      word <= emit_word;
    end
    else if (take)
      pend <= 1'b0;
  end

  a_word_width: assert property (@(posedge clock) disable iff (!rstn)
    emit && wbits == 6'h18 |=> word[7:0] == 8'h00)
    else $error("word has bits below sample width");
  a_emit_pulse: assert property (@(posedge clock) disable iff (!rstn)
    emit |=> !emit [*3])
    else $error("half-frame word emitted twice in a row");
endmodule : sipt_rx_chan

// *** sipt_src_model.sv ***
// Purpose: far-side model, eight serial audio sources and parallel source
// Assumes: stepped on the bench clock, one bit clock is 8 clock cycles
// Notes: bit clocks stand low outside frames but for the one park pulse; released data lines toggle
module sipt_src_model
(
  input wire logic clock,
  output logic [7:0] sclk,
  output logic [7:0] fsync,
  output logic [7:0] sdata,
  output logic par_clk,
  output logic par_frame,
  output logic [19:0] par_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import sipt_pkg::*;
  // quiet pins until the first frame
  initial
  begin
    sclk = 8'h00;
    fsync = 8'h00;
    sdata = 8'h00;
    par_clk = 1'b0;
    par_frame = 1'b0;
    par_data = 20'h00000;
  end
  // fsync level that marks a left half
  function automatic logic left_lvl(input sipt_fmt_type f);
    return f != SIPT_FMT_I2S;
  endfunction : left_lvl
  // park fsync on the right level so the first change opens a left half
  // one bit clock pulse lets the lanes learn the parked level; lanes
  // only compare sync against the level at their last rising edge
  task automatic park(input sipt_fmt_type f);
    @(posedge clock);
    fsync <= {8{~left_lvl(f)}};
    sdata <= ~sdata;
    repeat (4) @(posedge clock);
    sclk <= 8'hFF;
    repeat (4) @(posedge clock);
    sclk <= 8'h00;
  endtask : park
  // n halves on every lane, plus one closing boundary
  task automatic send(input sipt_fmt_type f, input int n,
    input logic [7:0][3:0][31:0] w);
    int e;
    int b;
    for (e = 0; e <= 32 * n; e++)
    begin
      // fsync and data move on the falling bit clock edge
      @(posedge clock);
      sclk <= 8'h00;
      fsync <= {8{left_lvl(f) ^ ((e / 32) % 2 == 1)}};
      // i2s data lags the boundary by one bit
      b = (f == SIPT_FMT_I2S) ? e - 1 : e;
      for (int l = 0; l < 8; l++)
      begin
        if (b < 0 || b >= 32 * n)
          sdata[l] <= ~sdata[l];
        else
          sdata[l] <= w[l][b / 32][31 - b % 32];
      end
      repeat (4) @(posedge clock);
      sclk <= 8'hFF;
      repeat (3) @(posedge clock);
    end
    // clock stops, data line released
    @(posedge clock);
    sclk <= 8'h00;
    sdata <= ~sdata;
  endtask : send
  // one parallel word per par_clk rise inside the frame
  task automatic par_send(input int n, input logic [3:0][19:0] d);
    int i;
    for (i = 0; i < n; i++)
    begin
      @(posedge clock);
      par_clk <= 1'b0;
      par_frame <= 1'b1;
      par_data <= d[i];
      repeat (4) @(posedge clock);
      par_clk <= 1'b1;
      repeat (3) @(posedge clock);
    end
    @(posedge clock);
    par_clk <= 1'b0;
    par_frame <= 1'b0;
    par_data <= ~par_data;
  endtask : par_send
endmodule : sipt_src_model
